// >>> rtl/ldcr_pkg.sv
// Contract
// - Triple-byte command loads front guard clock count 0-15, reset value 1.
// - Triple-byte command loads back guard clock count 0-15, reset value 0.
// - Partial off scans last index plus one; on scans window, plus icon lines when the icon bit is set.
// - Wrap off stops primary address; wrap on restarts it, steps the other.
// - Order bit picks column-first or page-first stepping.
// - Page steps +1 or -1 on wrap; no wrap holds column and page.
// - Fixed lines exclude twice the value rows, top or bottom by row mirror.
// - Two-bit line rate picks one of four rates per shade mode.
// - All-on forces every segment on, RAM untouched.
// - Inverse shows bitwise inverted RAM data, RAM untouched.
// - Enable clear sleeps; set restores power, then COM, then SEG.
// - Two-bit shade field selects on/off, 8, 4 or 16 shade decoding.
// - Nibble swap exchanges host byte nibbles on the way into RAM.
// - Mapping command sets icon, row mirror, column mirror, nibble swap.
// - Column mirror uses 255 minus column pointer for host RAM access.
// - Icon bit keeps the fixed icon rows shown during partial display.
// - Two-byte command sets 6-bit inversion line count and XOR select.
// - On/off mode pattern bit picks pixel width; select picks pattern.
// - Mode 100 lets top page bits choose the pattern being written.
// - Soft reset returns all control registers to defaults, RAM kept.
// - Bias select codes give ratios 5, 10, 11, 12.
// - Two-byte commands load last, first and end COM indexes.
package ldcr_pkg;
  localparam logic [7:0] CMD_TRIM = 8'h81;
  localparam logic [7:0] CMD_ISO = 8'h82;
  localparam logic [7:0] ISO_FRONT = 8'h13;
  localparam logic [7:0] ISO_BACK = 8'h14;
  localparam logic [7:0] CMD_MAP = 8'hC0;
  localparam logic [7:0] CMD_LINV = 8'hC8;
  localparam logic [7:0] CMD_RESET = 8'hE2;
  localparam logic [7:0] CMD_COMLAST = 8'hF1;
  localparam logic [7:0] CMD_WSTART = 8'hF2;
  localparam logic [7:0] CMD_WSTOP = 8'hF3;
  localparam int DSP_INV = 0;
  localparam int DSP_ALLON = 1;
  localparam int DSP_EN = 2;
  localparam int DSP_SHADE = 3;
  localparam int DSP_PMODE = 5;
  localparam int DSP_PSEL = 6;
  localparam int PNL_SWAP = 0;
  localparam int PNL_CMIR = 1;
  localparam int PNL_RMIR = 2;
  localparam int PNL_ICON = 3;
  localparam int STEP_WRAP = 0;
  localparam int STEP_ORDER = 1;
  localparam int STEP_DIR = 2;
  localparam logic [1:0] SH_ONOFF = 2'h0;
  localparam logic [1:0] SH_8 = 2'h1;
  localparam logic [1:0] SH_4 = 2'h2;
  localparam logic [1:0] PART_ON = 2'h3;
  localparam logic [2:0] PAT_MODE = 3'h4;
  localparam logic [7:0] COL_FLIP = 8'hFF;
  localparam int PWR_STEP_NS = 50;
  localparam int CLK_NS = 5;
  localparam int PWR_STEP_CYC = (PWR_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] VERSION_CODE = 4'h5; // Arbitrary value

  typedef enum {
    ST_IDLE, ST_ISO, ST_ISO_F, ST_ISO_B, ST_MAP, ST_LINV, ST_TRIM,
    ST_COMLAST, ST_WSTART, ST_WSTOP
  } ldcr_state_type;

  typedef struct packed {
    logic [3:0] guard_clocks_front;
    logic [3:0] guard_clocks_back;
    logic [1:0] partial_mode;
    logic [2:0] ram_stepping_control;
    logic [3:0] fixed_line_pairs;
    logic [1:0] line_rate_sel;
    logic [7:0] display_control_bits;
    logic [3:0] panel_control_bits;
    logic [6:0] line_invert_setting;
    logic [1:0] bias_select;
    logic [7:0] last_common_index;
    logic [7:0] active_first_row;
    logic [7:0] active_last_row;
    logic [7:0] bias_trim;
    logic [7:0] scroll_offset;
  } ldcr_cfg_type;

  localparam ldcr_cfg_type CFG_RESET = '{
    guard_clocks_front: 4'h1, guard_clocks_back: 4'h0,
    partial_mode: 2'h0, ram_stepping_control: 3'h1,
    fixed_line_pairs: 4'h0, line_rate_sel: 2'h2,
    display_control_bits: 8'h18, panel_control_bits: 4'h0,
    line_invert_setting: 7'h00, bias_select: 2'h2,
    last_common_index: 8'h9F, active_first_row: 8'h00,
    active_last_row: 8'h9F, bias_trim: 8'hEA, scroll_offset: 8'h00};
endpackage

// >>> rtl/ldcr_core.sv
// Design decisions made here: the register offsets and the plain strobed port.
module ldcr_core
  import ldcr_pkg::*;
#(
  parameter logic [7:0] COL_MAX = 8'hFF,
  parameter logic [6:0] PAGE_MAX = 7'h4F
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_cs_n,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output ldcr_cfg_type cfg,
  output logic [8:0] mux_rate,
  output logic [8:0] line_rate_tenths,
  output logic [3:0] bias_ratio,
  output logic [4:0] fixed_rows,
  output logic fixed_at_bottom,
  output logic ram_we,
  output logic [7:0] ram_col,
  output logic [6:0] ram_page,
  output logic [1:0] ram_pattern,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] seg_in,
  output logic [7:0] seg_out,
  output logic [3:0] shade_level,
  output logic power_en,
  output logic com_en,
  output logic seg_en
);
  typedef enum {PW_SLEEP, PW_POWER, PW_COM, PW_RUN} ldcr_pwr_type;

  ldcr_state_type st_q, st_d;
  ldcr_pwr_type pw_q;
  ldcr_cfg_type cfg_q;
  logic [7:0] col_q, col_d;
  logic [6:0] page_q, page_d;
  logic [7:0] ptr_col;
  logic [7:0] cnt_q;
  logic cmd_wr, dat_wr, soft_rst, wrap, order, dir, page_end;
  logic [7:0] b;

  function automatic logic [8:0] rate_of(input logic [1:0] sh,
                                         input logic [1:0] r);
    logic [8:0] t [16];
    t = '{9'd59, 9'd71, 9'd82, 9'd94, 9'd141, 9'd169, 9'd197, 9'd225,
          9'd133, 9'd160, 9'd187, 9'd214, 9'd200, 9'd240, 9'd280, 9'd320};
    return t[{sh, r}];
  endfunction

  function automatic logic [3:0] bias_of(input logic [1:0] s);
    logic [3:0] t [4];
    t = '{4'd5, 4'd10, 4'd11, 4'd12};
    return t[s];
  endfunction

  assign b = host_wdata;
  assign cmd_wr = host_wr && !host_cs_n && !host_addr;
  assign dat_wr = host_wr && !host_cs_n && host_addr;
  assign soft_rst = cmd_wr && st_q == ST_IDLE && b == CMD_RESET;
  assign cfg = cfg_q;
  assign wrap = cfg_q.ram_stepping_control[STEP_WRAP];
  assign order = cfg_q.ram_stepping_control[STEP_ORDER];
  assign dir = cfg_q.ram_stepping_control[STEP_DIR];
  assign page_end = dir ? page_q == 7'h00 : page_q == PAGE_MAX;

  // Pending byte tracking of multi-byte commands
  always_comb begin
    st_d = ST_IDLE;
    unique case (st_q)
      ST_IDLE: begin
        unique case (b)
          CMD_ISO: st_d = ST_ISO;
          CMD_MAP: st_d = ST_MAP;
          CMD_LINV: st_d = ST_LINV;
          CMD_TRIM: st_d = ST_TRIM;
          CMD_COMLAST: st_d = ST_COMLAST;
          CMD_WSTART: st_d = ST_WSTART;
          CMD_WSTOP: st_d = ST_WSTOP;
          default: st_d = ST_IDLE;
        endcase
      end
      ST_ISO: begin
        if (b == ISO_FRONT) begin
          st_d = ST_ISO_F;
        end else if (b == ISO_BACK) begin
          st_d = ST_ISO_B;
        end
      end
      ST_ISO_F, ST_ISO_B, ST_MAP, ST_LINV, ST_TRIM, ST_COMLAST,
      ST_WSTART, ST_WSTOP: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset || host_cs_n) begin
      st_q <= ST_IDLE;
    end else if (cmd_wr) begin
      st_q <= st_d;
    end
  end

  // Unlisted codes are simply ignored, which is one legal undefined outcome
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      cfg_q <= CFG_RESET;
    end else if (cmd_wr) begin
      unique case (st_q)
        ST_IDLE: begin
          casez (b)
            8'b0100_????: cfg_q.scroll_offset[3:0] <= b[3:0];
            8'b0101_????: cfg_q.scroll_offset[7:4] <= b[3:0];
            8'b1000_01??: cfg_q.partial_mode <= b[1:0];
            8'b1000_1???: cfg_q.ram_stepping_control <= b[2:0];
            8'b1001_????: cfg_q.fixed_line_pairs <= b[3:0];
            8'b1010_00??: cfg_q.line_rate_sel <= b[1:0];
            8'b1010_010?: cfg_q.display_control_bits[DSP_ALLON] <= b[0];
            8'b1010_011?: cfg_q.display_control_bits[DSP_INV] <= b[0];
            8'b1010_1???: cfg_q.display_control_bits[4:2] <= b[2:0];
            8'b1101_0???: cfg_q.display_control_bits[7:5] <= b[2:0];
            8'b1110_10??: cfg_q.bias_select <= b[1:0];
            default: ;
          endcase
        end
        ST_ISO_F: cfg_q.guard_clocks_front <= b[3:0];
        ST_ISO_B: cfg_q.guard_clocks_back <= b[3:0];
        ST_MAP: cfg_q.panel_control_bits <= b[3:0];
        ST_LINV: cfg_q.line_invert_setting <= b[6:0];
        ST_TRIM: cfg_q.bias_trim <= b;
        ST_COMLAST: cfg_q.last_common_index <= b;
        ST_WSTART: cfg_q.active_first_row <= b;
        ST_WSTOP: cfg_q.active_last_row <= b;
        default: ;
      endcase
    end
  end

  // Auto stepping after each data byte
  always_comb begin
    col_d = col_q;
    page_d = page_q;
    if (!order) begin
      if (col_q != COL_MAX) begin
        col_d = col_q + 8'h01;
      end else if (wrap) begin
        col_d = 8'h00;
        if (page_end) begin
          page_d = dir ? PAGE_MAX : 7'h00;
        end else begin
          page_d = dir ? page_q - 7'h01 : page_q + 7'h01;
        end
      end
    end else begin
      if (!page_end) begin
        page_d = dir ? page_q - 7'h01 : page_q + 7'h01;
      end else if (wrap) begin
        page_d = dir ? PAGE_MAX : 7'h00;
        col_d = col_q == COL_MAX ? 8'h00 : col_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      col_q <= 8'h00;
      page_q <= 7'h00;
    end else if (cmd_wr && st_q == ST_IDLE) begin
      casez (b)
        8'b0000_????: col_q[3:0] <= b[3:0];
        8'b0001_????: col_q[7:4] <= b[3:0];
        8'b0110_????: page_q[3:0] <= b[3:0];
        8'b0111_0???: page_q[6:4] <= b[2:0];
        default: ;
      endcase
    end else if (dat_wr) begin
      col_q <= col_d;
      page_q <= page_d;
    end
  end

  assign ptr_col = cfg_q.panel_control_bits[PNL_CMIR] ?
                   COL_FLIP - col_q : col_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ram_we <= 1'b0;
      ram_col <= 8'h00;
      ram_page <= 7'h00;
      ram_pattern <= 2'h0;
      ram_wdata <= 8'h00;
    end else begin
      ram_we <= dat_wr;
      ram_col <= ptr_col;
      ram_page <= page_q;
      ram_pattern <= cfg_q.display_control_bits[5:3] == PAT_MODE ?
                     page_q[6:5] : 2'h0;
      ram_wdata <= cfg_q.panel_control_bits[PNL_SWAP] ?
                   {b[3:0], b[7:4]} : b;
    end
  end

  // Scan, timing and bias figures
  always_ff @(posedge clk) begin
    if (reset) begin
      mux_rate <= 9'h000;
      line_rate_tenths <= 9'h000;
      bias_ratio <= 4'h0;
      fixed_rows <= 5'h00;
      fixed_at_bottom <= 1'b0;
    end else begin
      if (cfg_q.partial_mode == PART_ON) begin
        mux_rate <= {1'b0, cfg_q.active_last_row} -
                    {1'b0, cfg_q.active_first_row} + 9'h001 +
                    (cfg_q.panel_control_bits[PNL_ICON] ?
                     {4'h0, cfg_q.fixed_line_pairs, 1'b0} : 9'h000);
      end else begin
        mux_rate <= {1'b0, cfg_q.last_common_index} + 9'h001;
      end
      line_rate_tenths <= rate_of(cfg_q.display_control_bits[4:3],
                                  cfg_q.line_rate_sel);
      bias_ratio <= bias_of(cfg_q.bias_select);
      fixed_rows <= {cfg_q.fixed_line_pairs, 1'b0};
      fixed_at_bottom <= cfg_q.panel_control_bits[PNL_RMIR];
    end
  end
  // Icon rows count in the partial scan only when kept shown

  // Segment forcing never touches stored data, it only masks the path out
  always_ff @(posedge clk) begin
    if (reset) begin
      seg_out <= 8'h00;
      shade_level <= 4'h0;
    end else begin
      if (cfg_q.display_control_bits[DSP_ALLON]) begin
        seg_out <= 8'hFF;
      end else if (cfg_q.display_control_bits[DSP_INV]) begin
        seg_out <= ~seg_in;
      end else begin
        seg_out <= seg_in;
      end
      unique case (cfg_q.display_control_bits[4:3])
        SH_ONOFF: shade_level <= {4{seg_in[7]}};
        SH_8: shade_level <= {seg_in[6:4], seg_in[6]};
        SH_4: shade_level <= {seg_in[7:6], seg_in[7:6]};
        default: shade_level <= seg_in[7:4];
      endcase
    end
  end

  // Wake order: supply first so drivers never switch on a dead rail
  always_ff @(posedge clk) begin
    if (reset || !cfg_q.display_control_bits[DSP_EN]) begin
      pw_q <= PW_SLEEP;
      cnt_q <= 8'h00;
    end else if (pw_q != PW_RUN) begin
      if (pw_q == PW_SLEEP || cnt_q == 8'(PWR_STEP_CYC - 1)) begin
        cnt_q <= 8'h00;
        unique case (pw_q)
          PW_SLEEP: pw_q <= PW_POWER;
          PW_POWER: pw_q <= PW_COM;
          default: pw_q <= PW_RUN;
        endcase
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign power_en = pw_q != PW_SLEEP;
  assign com_en = pw_q == PW_COM || pw_q == PW_RUN;
  assign seg_en = pw_q == PW_RUN;

  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= {VERSION_CODE[0], cfg_q.panel_control_bits[PNL_CMIR],
                     cfg_q.panel_control_bits[PNL_RMIR], wrap,
                     cfg_q.display_control_bits[DSP_EN], 3'h0};
    end else begin
      host_rdata <= 8'h00;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_iso_front;
    cmd_wr && st_q == ST_ISO_F && !soft_rst |=>
      cfg_q.guard_clocks_front == $past(b[3:0]);
  endproperty
  a_iso_front: assert property (p_iso_front)
    else $error("front guard count not loaded");

  property p_iso_back;
    cmd_wr && st_q == ST_ISO_B && !soft_rst |=>
      cfg_q.guard_clocks_back == $past(b[3:0]);
  endproperty
  a_iso_back: assert property (p_iso_back)
    else $error("back guard count not loaded");

  property p_mux;
    ##1 cfg_q.partial_mode != PART_ON && $stable(cfg_q) |=>
      mux_rate == {1'b0, $past(cfg_q.last_common_index)} + 9'h001;
  endproperty
  a_mux: assert property (p_mux)
    else $error("mux rate wrong with partial off");

  property p_hold;
    dat_wr && !wrap && !order && col_q == COL_MAX |=>
      col_q == COL_MAX && $stable(page_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pointer moved past boundary without wrap");

  property p_mirror;
    dat_wr && cfg_q.panel_control_bits[PNL_CMIR] |=>
      ram_we && ram_col == COL_FLIP - $past(col_q);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirrored column address wrong");

  property p_swap;
    dat_wr && cfg_q.panel_control_bits[PNL_SWAP] |=>
      ram_wdata == {$past(b[3:0]), $past(b[7:4])};
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

  property p_allon;
    cfg_q.display_control_bits[DSP_ALLON] |=> seg_out == 8'hFF;
  endproperty
  a_allon: assert property (p_allon)
    else $error("segments not forced on");

  property p_inv;
    !cfg_q.display_control_bits[DSP_ALLON] &&
      cfg_q.display_control_bits[DSP_INV] |=> seg_out == ~$past(seg_in);
  endproperty
  a_inv: assert property (p_inv)
    else $error("segments not inverted");

  property p_wake;
    $rose(power_en) |-> !com_en ##[1:20] com_en && !seg_en;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake order broken");

  property p_deselect;
    host_cs_n |=> st_q == ST_IDLE;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("pending command survived deselect");

  property p_soft;
    soft_rst |=> cfg_q == CFG_RESET && col_q == 8'h00;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset left state");

  property p_wrap;
    dat_wr && wrap && !order && col_q == COL_MAX |=> col_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("column did not restart on wrap");

  property p_pattern;
    dat_wr && cfg_q.display_control_bits[5:3] == PAT_MODE |=>
      ram_pattern == $past(page_q[6:5]);
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("write pattern select wrong");

  c_iso: cover property (cmd_wr && st_q == ST_ISO_F);
  c_wrap: cover property (dat_wr && wrap && col_q == COL_MAX);
  c_wake: cover property (seg_en && !$past(seg_en));
  c_abort: cover property (st_q != ST_IDLE && host_cs_n);
endmodule

// >>> dv/ldcr_host_model.sv
module ldcr_host_model (
  input wire logic clk,
  input wire logic [7:0] host_rdata,
  output logic host_cs_n,
  output logic host_wr,
  output logic host_rd,
  output logic host_addr,
  output logic [7:0] host_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_cs_n = 1'b1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 1'b0;
    host_wdata = 8'h00;
  end

  // Callers also issue the unlisted code 8'hE3, which the core must ignore
  // Select stays low across multi-byte commands
  task automatic put(input logic a, input logic [7:0] b);
    @(posedge clk);
    host_cs_n <= 1'b0;
    host_addr <= a;
    host_wdata <= b;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    // Stale data would hide a late capture
    host_wdata <= ~b;
  endtask

  task automatic deselect;
    @(posedge clk);
    host_cs_n <= 1'b1;
    @(posedge clk);
    host_cs_n <= 1'b0;
  endtask

  task automatic rd(output logic [7:0] d);
    @(posedge clk);
    host_cs_n <= 1'b0;
    host_addr <= 1'b0;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask
endmodule

// >>> dv/lcd_display_command_regs_tb_top.sv
module lcd_display_command_regs_tb_top import ldcr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, host_cs_n, host_wr, host_rd, host_addr;
  logic [7:0] host_wdata, host_rdata, ram_col, ram_wdata, seg_in, seg_out;
  logic [7:0] rd_v;
  ldcr_cfg_type cfg;
  logic [8:0] mux_rate, line_rate_tenths;
  logic [3:0] bias_ratio, shade_level;
  logic [4:0] fixed_rows;
  logic [6:0] ram_page;
  logic [1:0] ram_pattern;
  logic fixed_at_bottom, ram_we, power_en, com_en, seg_en;
  int err_count = 0;
  int total_checks = 0;
  int n;
  logic [8:0] rate_tbl [16] = '{59, 71, 82, 94, 141, 169, 197, 225,
    133, 160, 187, 214, 200, 240, 280, 320};
  logic [3:0] bias_tbl [4] = '{4'h5, 4'hA, 4'hB, 4'hC};
  logic [3:0] shade_tbl [4] = '{4'h0, 4'hB, 4'h5, 4'h5};

  ldcr_core dut_u (.clk(clk), .reset(reset), .host_cs_n(host_cs_n),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .cfg(cfg),
    .mux_rate(mux_rate), .line_rate_tenths(line_rate_tenths),
    .bias_ratio(bias_ratio), .fixed_rows(fixed_rows),
    .fixed_at_bottom(fixed_at_bottom), .ram_we(ram_we), .ram_col(ram_col),
    .ram_page(ram_page), .ram_pattern(ram_pattern), .ram_wdata(ram_wdata),
    .seg_in(seg_in), .seg_out(seg_out), .shade_level(shade_level),
    .power_en(power_en), .com_en(com_en), .seg_en(seg_en));

  ldcr_host_model host_u (.clk(clk), .host_rdata(host_rdata),
    .host_cs_n(host_cs_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [79:0] seen,
                     input logic [79:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    host_u.put(1'b0, b);
  endtask

  task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
    cmd(a);
    cmd(b);
  endtask

  // Derived outputs trail the command by one more cycle
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic setcp(input logic [7:0] c, input logic [6:0] p);
    cmd({4'h0, c[3:0]});
    cmd({4'h1, c[7:4]});
    cmd({4'h6, p[3:0]});
    cmd({5'h0E, p[6:4]});
  endtask

  task automatic dat(input logic [7:0] b, input logic [7:0] c,
                     input logic [6:0] p, input logic [7:0] w);
    host_u.put(1'b1, b);
    #1;
    chk("ram_we", ram_we, 1'b1);
    chk("ram_col", ram_col, c);
    chk("ram_page", ram_page, p);
    chk("ram_wdata", ram_wdata, w);
  endtask

  task automatic wait_hi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    seg_in = 8'h5A;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk("front", cfg.guard_clocks_front, 4'h1);
    chk("back", cfg.guard_clocks_back, 4'h0);
    chk("fixed", cfg.fixed_line_pairs, 4'h0);
    chk("disp_en", cfg.display_control_bits[4:2], 3'b110);
    chk("line_inv", cfg.line_invert_setting, 7'h00);
    chk("bias", bias_ratio, 4'hB);
    chk("mux", mux_rate, 9'd160);
    host_u.rd(rd_v);
    chk("status", rd_v, {VERSION_CODE[0], 7'h10});
    cmd(8'hE3);
    settle();
    chk("nop", cfg, CFG_RESET);
    cmd(8'h82);
    cmd2(8'h13, 8'h05);
    cmd(8'h82);
    cmd2(8'h14, 8'h0F);
    settle();
    chk("front", cfg.guard_clocks_front, 4'h5);
    chk("back", cfg.guard_clocks_back, 4'hF);
    cmd2(8'h82, 8'h13);
    host_u.deselect();
    cmd(8'h07);
    settle();
    chk("abort", cfg.guard_clocks_front, 4'h5);
    cmd2(8'hF1, 8'h3F);
    settle();
    chk("mux", mux_rate, 9'd64);
    cmd2(8'hF2, 8'h10);
    cmd2(8'hF3, 8'h1F);
    cmd(8'h93);
    cmd2(8'hC0, 8'h08);
    cmd(8'h87);
    settle();
    chk("mux", mux_rate, 9'd22);
    chk("fixed_rows", fixed_rows, 5'd6);
    cmd2(8'hC0, 8'h04);
    settle();
    chk("mux", mux_rate, 9'd16);
    chk("bottom", fixed_at_bottom, 1'b1);
    chk("panel", cfg.panel_control_bits, 4'h4);
    cmd(8'h84);
    settle();
    chk("mux", mux_rate, 9'd64);
    for (int s = 0; s < 4; s++) begin
      cmd({5'h15, s[1:0], 1'b0});
      for (int r = 0; r < 4; r++) begin
        cmd({6'h28, r[1:0]});
        settle();
        chk("rate", line_rate_tenths, rate_tbl[s*4+r]);
      end
      chk("shade", shade_level, shade_tbl[s]);
    end
    for (int b = 0; b < 4; b++) begin
      cmd({6'h3A, b[1:0]});
      settle();
      chk("bias", bias_ratio, bias_tbl[b]);
    end
    cmd(8'hA5);
    settle();
    chk("seg", seg_out, 8'hFF);
    cmd(8'hA4);
    cmd(8'hA7);
    settle();
    chk("seg", seg_out, 8'hA5);
    cmd(8'hA6);
    settle();
    chk("seg", seg_out, 8'h5A);
    cmd2(8'hC0, 8'h01);
    setcp(8'h00, 7'h00);
    dat(8'h3C, 8'h00, 7'h00, 8'hC3);
    cmd2(8'hC0, 8'h02);
    setcp(8'h05, 7'h00);
    dat(8'h11, 8'hFA, 7'h00, 8'h11);
    cmd2(8'hC0, 8'h00);
    setcp(8'hFF, 7'h00);
    dat(8'h3C, 8'hFF, 7'h00, 8'h3C);
    dat(8'h3C, 8'h00, 7'h01, 8'h3C);
    cmd(8'h8D);
    setcp(8'hFF, 7'h05);
    dat(8'h3C, 8'hFF, 7'h05, 8'h3C);
    dat(8'h3C, 8'h00, 7'h04, 8'h3C);
    cmd(8'h88);
    setcp(8'hFF, 7'h03);
    dat(8'h3C, 8'hFF, 7'h03, 8'h3C);
    dat(8'h3C, 8'hFF, 7'h03, 8'h3C);
    cmd(8'h8B);
    setcp(8'h07, 7'h4F);
    dat(8'h3C, 8'h07, 7'h4F, 8'h3C);
    dat(8'h3C, 8'h08, 7'h00, 8'h3C);
    cmd(8'hA8);
    cmd(8'hD1);
    setcp(8'h00, 7'h40);
    host_u.put(1'b1, 8'h3C);
    #1;
    chk("pattern", ram_pattern, 2'b10);
    cmd(8'hD7);
    settle();
    chk("disp_pat", cfg.display_control_bits[7:5], 3'b111);
    cmd(8'hAF);
    wait_hi(power_en);
    chk("power", power_en, 1'b1);
    chk("com", com_en, 1'b0);
    wait_hi(com_en);
    chk("com_gap", n >= PWR_STEP_CYC - 1 && n <= PWR_STEP_CYC + 1, 1'b1);
    chk("seg_en", seg_en, 1'b0);
    wait_hi(seg_en);
    chk("seg_gap", n >= PWR_STEP_CYC - 1 && n <= PWR_STEP_CYC + 1, 1'b1);
    cmd(8'hAE);
    settle();
    chk("sleep", {power_en, com_en, seg_en}, 3'b000);
    cmd2(8'hC8, 8'h45);
    cmd2(8'h81, 8'h12);
    settle();
    chk("line_inv", cfg.line_invert_setting, 7'h45);
    chk("trim", cfg.bias_trim, 8'h12);
    cmd(8'hE2);
    settle();
    chk("soft_reset", cfg, CFG_RESET);
    summarize();
  end
endmodule
